// file: ltmu_peer.sv
// Purpose: Far end of the link: echoes our tests, carries injected units
// Assumes: Mode 0 echo, 1 corrupt echo, 2 silent
// Notes:   Idle payload toggles so stale data never matches
module ltmu_peer (
  input  wire logic               mclk,
  input  wire logic               reset_n,
  input  wire ltmu_pkg::ltmu_su_t tx_su,
  output logic                    tx_ready,
  output ltmu_pkg::ltmu_su_t      rx_su,
  input  wire ltmu_pkg::ltmu_su_t inj,
  input  wire logic [1:0]         mode,
  input  wire logic               stall,
  output ltmu_pkg::ltmu_su_t      seen,
  output logic                    seen_stb
);
  ltmu_pkg::ltmu_su_t ack_q; // Echo waiting to leave
  logic [7:0]         lag_q; // Cycles left before echo
  assign tx_ready = !stall;
  // Injected units win over a due echo; the bench avoids the clash
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_su    <= '0;
      ack_q    <= '0;
      lag_q    <= 8'h00;
      seen     <= '0;
      seen_stb <= 1'b0;
    end
    else
    begin
      rx_su.valid <= 1'b0;
      rx_su.information_payload_field <= ~rx_su.information_payload_field;
      seen_stb <= tx_su.valid && tx_ready;
      if (lag_q != 8'h00)
        lag_q <= lag_q - 8'h01;
      if (lag_q == 8'h01)
        rx_su <= ack_q;
      if (tx_su.valid && tx_ready && mode != 2'h2 &&
          tx_su.information_payload_field.signal_type_code
            == ltmu_pkg::SIG_TEST)
      begin
        ack_q <= tx_su;
        ack_q.information_payload_field.signal_type_code
          <= ltmu_pkg::SIG_ACK;
        ack_q.information_payload_field.pattern
          <= tx_su.information_payload_field.pattern ^ {119'h0, mode[0]};
        lag_q <= 8'h03;
      end
      if (tx_su.valid && tx_ready)
        seen <= tx_su;
      if (inj.valid)
        rx_su <= inj;
    end
  end
endmodule : ltmu_peer

// file: ltmu_pkg.sv
// Purpose: Shared constants and carriers of the link test message unit
// Assumes: 125 MHz mclk; message fields packed first-sent bit at bit 0
// Notes:   Pattern octet k sits at bits 8k+7:8k of the pattern field
package ltmu_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 125_000_000; // mclk rate
  localparam int unsigned ACK_DEADLINE_MS = 100;         // Answer limit
  localparam int unsigned ACK_WAIT_MS     = 1000;        // Wait for ack
  localparam int unsigned TEST_PERIOD_MS  = 10000;       // Test spacing
  // Longest time rounds down, least time rounds up
  localparam logic [31:0] ACK_DEADLINE_CYC =
    32'((64'(ACK_DEADLINE_MS) * 64'(CLK_HZ)) / 64'd1000);
  localparam logic [31:0] ACK_WAIT_CYC =
    32'((64'(ACK_WAIT_MS) * 64'(CLK_HZ) + 64'd999) / 64'd1000);
  localparam logic [31:0] TEST_PERIOD_CYC =
    32'((64'(TEST_PERIOD_MS) * 64'(CLK_HZ)) / 64'd1000);

  // ------------------------------------------------------------------
  // Field codes and sizes
  // ------------------------------------------------------------------
  localparam logic [3:0] SI_TEST_MAINT  = 4'h1; // Service indicator
  localparam logic [3:0] GRP_TEST       = 4'h1; // Test message group
  localparam logic [3:0] SIG_TEST       = 4'h1; // Link test message
  localparam logic [3:0] SIG_ACK        = 4'h2; // Link test ack
  localparam logic [3:0] SPARE_TX       = 4'h0; // Spare bits sent
  localparam int unsigned PAT_OCTETS    = 15;   // Most pattern octets
  localparam logic [3:0] OWN_PAT_LEN    = 4'h4; // Octets we send
  localparam logic [7:0] LFSR_SEED      = 8'h5a; // Nonzero start
  localparam logic [7:0] LFSR_TAPS      = 8'hb8; // Maximal 8-bit taps
  localparam logic [4:0] HDR_OCTETS     = 5'h06; // Label plus headings
  localparam int unsigned SLC_LSB       = 28;   // Link code in label

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed
  {
    logic [8*PAT_OCTETS-1:0] pattern; // Last sent
    logic [3:0]              length;  // Pattern octets
    logic [3:0]              spare;   // Zero on send
    logic [3:0]              signal_type_code;
    logic [3:0]              message_group_code;
    logic [31:0]             label;   // First sent
  } ltmu_msg_t;

  typedef struct packed
  {
    logic       valid;             // Message present
    logic [3:0] sub_service_bits;  // Network indicator bits
    logic [3:0] service_ind;       // Service indicator
    logic [4:0] octets;            // Payload octet count
    ltmu_msg_t  information_payload_field;
  } ltmu_su_t;

  typedef enum logic [1:0]
  {
    LTMU_IDLE = 2'b00, // Waiting for test period
    LTMU_SEND = 2'b01, // Test queued for link
    LTMU_WAIT = 2'b11  // Awaiting acknowledgement
  } ltmu_state_t;

endpackage : ltmu_pkg

// file: ltmu_properties.sv
// Purpose: Port checks of the unit
// Assumes: One clock; bound to ltmu_top
// Notes:   Counters stand in for the long waits
module ltmu_properties #(
  parameter logic [31:0] ACK_DEADLINE = ltmu_pkg::ACK_DEADLINE_CYC,
  parameter logic [31:0] ACK_WAIT     = ltmu_pkg::ACK_WAIT_CYC
)(
  input wire logic               mclk,
  input wire logic               reset_n,
  input wire logic [3:0]         link_code,
  input wire ltmu_pkg::ltmu_su_t rx_su,
  input wire ltmu_pkg::ltmu_su_t tx_su,
  input wire logic               tx_ready,
  input wire logic               test_pass,
  input wire logic               test_retry,
  input wire logic               mgmt_alarm,
  input wire logic               ack_dropped
);
  typedef struct packed
  {
    logic [31:0] owe; // Age of owed ack
    logic [31:0] wt;  // Age of own test
    logic        rs;  // Repeat under way
  } ltmu_chk_t;
  ltmu_chk_t           c_q, c_d;
  ltmu_pkg::ltmu_msg_t rp, tp;
  logic                rx_tst, tx_ack, tx_tst;
  assign rp     = rx_su.information_payload_field;
  assign tp     = tx_su.information_payload_field;
  assign rx_tst = rx_su.valid && rx_su.service_ind == ltmu_pkg::SI_TEST_MAINT
    && rp.message_group_code == ltmu_pkg::GRP_TEST
    && rp.signal_type_code == ltmu_pkg::SIG_TEST
    && rx_su.octets == ltmu_pkg::HDR_OCTETS + 5'(rp.length);
  assign tx_ack = tx_su.valid && tp.signal_type_code == ltmu_pkg::SIG_ACK;
  assign tx_tst = tx_su.valid && tp.signal_type_code == ltmu_pkg::SIG_TEST;
  // Only octets named by the length take part
  function automatic logic pat_eq(logic [119:0] a, logic [119:0] b,
                                  logic [3:0] n);
    return ((a ^ b) & ((120'h1 << (8 * n)) - 120'h1)) == 120'h0;
  endfunction : pat_eq
  // Ages restart on each cause, so waits never need long repeats
  always_comb
  begin
    c_d = c_q;
    if (rx_tst)
      c_d.owe = 32'h1;
    else if ((tx_ack && tx_ready) || ack_dropped)
      c_d.owe = 32'h0;
    else if (c_q.owe != 32'h0)
      c_d.owe = c_q.owe + 32'h1;
    if (test_pass || test_retry || mgmt_alarm)
      c_d.wt = 32'h0;
    else if (c_q.wt != 32'h0)
      c_d.wt = c_q.wt + 32'h1;
    else if (tx_tst)
      c_d.wt = 32'h1;
    if (test_retry)
      c_d.rs = 1'b1;
    else if (test_pass || mgmt_alarm)
      c_d.rs = 1'b0;
  end
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      c_q <= '0;
    else
      c_q <= c_d;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_test_in;
    rx_tst && !tx_su.valid ##1 !rx_su.valid && !tx_su.valid;
  endsequence
  sequence s_bad_in;
    rx_su.valid && !rx_tst && c_q.owe == 32'h0 ##1 !rx_su.valid;
  endsequence
  a_ack_echo: assert property (s_test_in |=> tx_ack
    && pat_eq(tp.pattern, $past(rp.pattern, 2), tp.length)
    && tp.length == $past(rp.length, 2)) else $error("ack missing");
  a_frame_fields: assert property (tx_su.valid |->
    (tx_ack || tx_tst) && tx_su.service_ind == ltmu_pkg::SI_TEST_MAINT
    && tp.message_group_code == ltmu_pkg::GRP_TEST
    && tp.spare == ltmu_pkg::SPARE_TX && tp.label[31:28] == link_code
    && tx_su.octets == ltmu_pkg::HDR_OCTETS + 5'(tp.length))
    else $error("bad frame fields");
  a_own_length: assert property (tx_tst |->
    tp.length == ltmu_pkg::OWN_PAT_LEN) else $error("own length");
  a_tx_holds: assert property (tx_su.valid && !tx_ready |=>
    $stable(tx_su) || ack_dropped) else $error("offer changed");
  a_ack_deadline: assert property (c_q.owe <= ACK_DEADLINE + 32'h1)
    else $error("ack owed too long");
  a_drop_bad: assert property (s_bad_in |=> !tx_ack)
    else $error("answered bad message");
  a_pass_cause: assert property (test_pass |-> $past(rx_su.valid)
    && $past(rp.signal_type_code) == ltmu_pkg::SIG_ACK)
    else $error("pass without ack");
  a_wait_bound: assert property (c_q.wt <= ACK_WAIT + 32'h3)
    else $error("wait too long");
  a_fail_late: assert property ((test_retry || mgmt_alarm)
    && !$past(rx_su.valid) |-> c_q.wt >= ACK_WAIT - 32'h2)
    else $error("early timeout");
  a_retry_once: assert property (test_retry |-> !c_q.rs)
    else $error("second repeat");
  a_alarm_second: assert property (mgmt_alarm |-> c_q.rs)
    else $error("alarm without repeat");
endmodule : ltmu_properties

bind ltmu_top ltmu_properties #(
  .ACK_DEADLINE(ACK_DEADLINE),
  .ACK_WAIT(ACK_WAIT)
) u_props (
  .mclk(mclk), .reset_n(reset_n),
  .link_code(link_code), .rx_su(rx_su), .tx_su(tx_su),
  .tx_ready(tx_ready), .test_pass(test_pass), .test_retry(test_retry),
  .mgmt_alarm(mgmt_alarm), .ack_dropped(ack_dropped)
);

// file: ltmu_top.sv
// Purpose: Link test message unit: answers tests, runs own tests
// Assumes: Link side logic on mclk; one message offered per rx pulse
// Notes:   Acks take priority over own tests on the transmit port, save in a cycle when a newer test replaces the owed ack
//
// How it works
// R1 - Answer each test within 100 ms; the code drops an ack not sent by then, or one replaced by a newer test
// R2 - Ack echoes received pattern exactly
// R3 - Acks always; own tests optional
// R4 - Own test sent periodically while in service
// R5 - Own tests independent of peer tests
// R6 - Matching ack ends test quietly
// R7 - No ack in 1 s fails test
// R8 - Wrong pattern ack fails test
// R9 - First failure repeats test once
// R10 - Second failure alerts management
// R11 - Service indicator 0001 on test traffic
// R12 - Payload is whole octets
// R13 - Group code 0001 means test messages
// R14 - Fixed field order, label sent first
// R15 - Signal code 0001 test, 0010 ack
// R16 - Length field counts pattern octets
// R17 - Label carries this link's code
// R18 - Spare bits sent zero, ignored received
// R19 - Drop spare group or undefined signal
module ltmu_top #(
  parameter logic [31:0] ACK_DEADLINE = ltmu_pkg::ACK_DEADLINE_CYC,
  parameter logic [31:0] ACK_WAIT     = ltmu_pkg::ACK_WAIT_CYC,
  parameter logic [31:0] TEST_PERIOD  = ltmu_pkg::TEST_PERIOD_CYC
)(
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              in_service,
  input  wire logic              originate_en,
  input  wire logic [31:0]       own_label,
  input  wire logic [3:0]        link_code,
  input  wire ltmu_pkg::ltmu_su_t rx_su,
  output ltmu_pkg::ltmu_su_t     tx_su,
  input  wire logic              tx_ready,
  output logic                   test_pass,
  output logic                   test_retry,
  output logic                   mgmt_alarm,
  output logic                   ack_dropped
);

  // ------------------------------------------------------------------
  // State record
  // ------------------------------------------------------------------
  typedef struct packed
  {
    ltmu_pkg::ltmu_state_t ost;        // Own test sequencer
    logic                  retry;      // Repeat test running
    logic [31:0]           timer;      // Period or ack wait
    logic [7:0]            lfsr;       // Pattern source
    ltmu_pkg::ltmu_msg_t   sent;       // Last test sent
    logic                  ack_pend;   // Ack owed to peer
    logic [31:0]           ack_age;    // Cycles since test arrived
    ltmu_pkg::ltmu_su_t    ack_su;     // Ack waiting for link
    ltmu_pkg::ltmu_su_t    tx;         // Offered unit
    logic                  pass;       // Pulse
    logic                  retry_ev;   // Pulse
    logic                  alarm;      // Pulse
    logic                  drop;       // Pulse
  } ltmu_reg_t;

  ltmu_reg_t st_q;      // Registered state
  ltmu_reg_t st_d;      // Next state
  logic      rst_s1_q;  // Reset release stage one
  logic      rst_s2_q;  // Reset release stage two, used below

  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  // Asserts at once, releases two edges later to avoid recovery issues
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Compare only the octets that the length field covers
  function automatic logic pat_equal(
    input logic [8*ltmu_pkg::PAT_OCTETS-1:0] a,
    input logic [8*ltmu_pkg::PAT_OCTETS-1:0] b,
    input logic [3:0]                        len
  );
    logic eq;
    eq = 1'b1;
    for (int k = 0; k < ltmu_pkg::PAT_OCTETS; k++)
    begin
      if (k < int'(len) && a[8*k +: 8] != b[8*k +: 8])
      begin
        eq = 1'b0;
      end
    end
    return eq;
  endfunction : pat_equal

  // Own pattern: LFSR value offset per octet, zero past the length
  function automatic logic [8*ltmu_pkg::PAT_OCTETS-1:0] own_pattern(
    input logic [7:0] seed
  );
    logic [8*ltmu_pkg::PAT_OCTETS-1:0] p;
    p = '0;
    for (int k = 0; k < ltmu_pkg::PAT_OCTETS; k++)
    begin
      if (k < int'(ltmu_pkg::OWN_PAT_LEN))
      begin
        p[8*k +: 8] = seed + 8'(k);
      end
    end
    return p;
  endfunction : own_pattern

  // Label with this link's code placed in its link code field
  function automatic logic [31:0] link_label(
    input logic [31:0] lbl,
    input logic [3:0]  slc
  );
    logic [31:0] l;
    l = lbl;
    l[ltmu_pkg::SLC_LSB +: 4] = slc;
    return l;
  endfunction : link_label

  // ------------------------------------------------------------------
  // Receive decode
  // ------------------------------------------------------------------
  logic rx_ok;   // Well formed testing message
  logic rx_test; // Peer test arrived
  logic rx_ack;  // Ack to our test arrived

  // Spare bits never looked at; foreign codes fall through unused
  always_comb
  begin
    rx_ok = rx_su.valid &&
            rx_su.service_ind == ltmu_pkg::SI_TEST_MAINT &&         // R11
            rx_su.information_payload_field.message_group_code ==
              ltmu_pkg::GRP_TEST &&                                 // R13
            rx_su.octets == ltmu_pkg::HDR_OCTETS +
              5'(rx_su.information_payload_field.length);         // R16
    rx_test = rx_ok && rx_su.information_payload_field.signal_type_code
              == ltmu_pkg::SIG_TEST;                                // R19
    rx_ack  = rx_ok && rx_su.information_payload_field.signal_type_code
              == ltmu_pkg::SIG_ACK;                                 // R19
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    logic ack_ok;   // Returned ack matches
    logic failed;   // Current test failed this cycle
    logic tx_free;  // Offer slot empty next
    ack_ok  = 1'b0;
    failed  = 1'b0;
    tx_free = 1'b0;
    st_d = st_q;
    st_d.pass     = 1'b0;
    st_d.retry_ev = 1'b0;
    st_d.alarm    = 1'b0;
    st_d.drop     = 1'b0;
    // Free running pattern source
    st_d.lfsr = {1'b0, st_q.lfsr[7:1]} ^
                (st_q.lfsr[0] ? ltmu_pkg::LFSR_TAPS : 8'h00);
    st_d.ack_age = st_q.ack_age + 32'h1;

    // Transmit slot drains on handshake
    if (st_q.tx.valid && tx_ready)
    begin
      st_d.tx.valid = 1'b0;
    end
    tx_free = !st_d.tx.valid;

    // Acknowledgement side, present in every build                  R3
    if (rx_test)
    begin
      // Newest test replaces any ack not yet offered to the link
      st_d.ack_pend = 1'b1;
      st_d.ack_age  = '0;
      st_d.ack_su.valid            = 1'b1;
      st_d.ack_su.sub_service_bits = rx_su.sub_service_bits;
      st_d.ack_su.service_ind      = ltmu_pkg::SI_TEST_MAINT;      // R11
      st_d.ack_su.octets           = rx_su.octets;                 // R12
      st_d.ack_su.information_payload_field =
        rx_su.information_payload_field;                           // R2
      st_d.ack_su.information_payload_field.label =
        link_label(rx_su.information_payload_field.label,
                   link_code);                                     // R17
      st_d.ack_su.information_payload_field.signal_type_code =
        ltmu_pkg::SIG_ACK;                                         // R15
      st_d.ack_su.information_payload_field.spare =
        ltmu_pkg::SPARE_TX;                                        // R18
    end
    else if (st_q.ack_pend)
    begin
      if (tx_free)
      begin
        // Ack goes out ahead of our own test                        R1
        st_d.tx       = st_q.ack_su;
        st_d.ack_pend = 1'b0;
      end
      else if (st_q.ack_age >= ACK_DEADLINE - 32'h1)
      begin
        // Too late to honour the limit; a stale ack helps no one    R1
        st_d.ack_pend = 1'b0;
        st_d.drop     = 1'b1;
      end
    end
    if (st_q.ack_pend && !rx_test)
    begin
      tx_free = 1'b0;
    end
    // An ack the link keeps refusing is pulled at the limit as well
    if (st_q.tx.valid && !tx_ready &&
        st_q.ack_age >= ACK_DEADLINE - 32'h1 &&
        st_q.tx.information_payload_field.signal_type_code ==
          ltmu_pkg::SIG_ACK)
    begin
      st_d.tx.valid = 1'b0; // R1
      st_d.drop     = 1'b1;
    end

    // Own test sequencer, run by its own timer and the returned acks R5
    case (st_q.ost)
      ltmu_pkg::LTMU_IDLE:
      begin
        st_d.retry = 1'b0;
        if (!(in_service && originate_en))
        begin
          st_d.timer = '0;                                         // R3
        end
        else if (st_q.timer >= TEST_PERIOD - 32'h1)
        begin
          st_d.timer = '0;
          st_d.ost   = ltmu_pkg::LTMU_SEND;                        // R4
          st_d.sent.label = link_label(own_label, link_code);      // R17
          st_d.sent.message_group_code = ltmu_pkg::GRP_TEST;       // R13
          st_d.sent.signal_type_code   = ltmu_pkg::SIG_TEST;       // R15
          st_d.sent.spare   = ltmu_pkg::SPARE_TX;                  // R18
          st_d.sent.length  = ltmu_pkg::OWN_PAT_LEN;               // R16
          st_d.sent.pattern = own_pattern(st_q.lfsr);
        end
        else
        begin
          st_d.timer = st_q.timer + 32'h1;
        end
      end
      ltmu_pkg::LTMU_SEND:
      begin
        if (!in_service)
        begin
          st_d.ost = ltmu_pkg::LTMU_IDLE;
        end
        else if (tx_free)
        begin
          st_d.tx.valid            = 1'b1;
          st_d.tx.sub_service_bits = 4'h0;
          st_d.tx.service_ind      = ltmu_pkg::SI_TEST_MAINT;      // R11
          st_d.tx.octets = ltmu_pkg::HDR_OCTETS +
                           5'(st_q.sent.length);                   // R12
          st_d.tx.information_payload_field = st_q.sent;           // R14
          st_d.timer = '0;
          st_d.ost   = ltmu_pkg::LTMU_WAIT;
        end
      end
      ltmu_pkg::LTMU_WAIT:
      begin
        // Timer runs from the offer; link holdoff counts against it
        if (rx_ack)
        begin
          ack_ok = pat_equal(
            rx_su.information_payload_field.pattern,
            st_q.sent.pattern, st_q.sent.length) &&
            rx_su.information_payload_field.length ==
            st_q.sent.length;
          if (ack_ok)
          begin
            st_d.pass = 1'b1;                                      // R6
          end
          else
          begin
            failed = 1'b1;                                         // R8
          end
        end
        else if (st_q.timer >= ACK_WAIT - 32'h1)
        begin
          failed = 1'b1;                                           // R7
        end
        else
        begin
          st_d.timer = st_q.timer + 32'h1;
        end
        if (ack_ok)
        begin
          st_d.ost   = ltmu_pkg::LTMU_IDLE;
          st_d.timer = '0;
          st_d.retry = 1'b0;
        end
        else if (failed && !st_q.retry)
        begin
          // Fresh pattern for the single repeat                     R9
          st_d.retry       = 1'b1;
          st_d.retry_ev    = 1'b1;
          st_d.ost         = ltmu_pkg::LTMU_SEND;
          st_d.sent.pattern = own_pattern(st_q.lfsr);
        end
        else if (failed)
        begin
          st_d.alarm = 1'b1;                                       // R10
          st_d.retry = 1'b0;
          st_d.timer = '0;
          st_d.ost   = ltmu_pkg::LTMU_IDLE;
        end
      end
      default:
      begin
        st_d.ost = ltmu_pkg::LTMU_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_s2_q)
  begin
    if (!rst_s2_q)
    begin
      st_q       <= '0;
      st_q.lfsr  <= ltmu_pkg::LFSR_SEED;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, all straight from the state register
  // ------------------------------------------------------------------
  assign tx_su       = st_q.tx;
  assign test_pass   = st_q.pass;
  assign test_retry  = st_q.retry_ev;
  assign mgmt_alarm  = st_q.alarm;
  assign ack_dropped = st_q.drop;

endmodule : ltmu_top

// file: ltmu_top_test.sv
// Purpose: Self-checking bench
// Assumes: Short timers; peer model on the link
// Notes:   Table for received units, hand tests after
module ltmu_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] AW = 32'd200; // Ack wait cycles
  localparam logic [31:0] TP = 32'd400; // Test period cycles
  typedef struct packed
  {
    logic       ans; // Ack expected
    logic [3:0] len, sig, grp, si, spr;
  } ltmu_row_t;
  // Digits: ack, length, signal, group, service, spare
  ltmu_row_t rows [10] = '{21'h141110, 21'h1f1110, 21'h101110,
    21'h141115, 21'h041010, 21'h041210, 21'h043110, 21'h040110,
    21'h042110, 21'h041100};
  logic mclk = 0, reset_n = 0, in_service = 0, originate_en = 0;
  logic stall = 0, tx_ready, seen_stb, hit;
  logic test_pass, test_retry, mgmt_alarm, ack_dropped;
  logic [31:0] own_label = 32'h5123_4567;
  logic [3:0]  link_code = 4'h9;
  logic [1:0]  mode = 2'h0;
  ltmu_pkg::ltmu_su_t rx_su, tx_su, seen, u, got, inj = '0;
  int miscompares = 0, checks_done = 0, cyc = 0, k;
  int n_pass, n_retry, n_alarm, n_drop, n_tst, t_off, dret;
  always #4 mclk = ~mclk;
  ltmu_top #(.ACK_DEADLINE(32'd50), .ACK_WAIT(AW), .TEST_PERIOD(TP)) dut (
    .mclk(mclk), .reset_n(reset_n), .in_service(in_service),
    .originate_en(originate_en), .own_label(own_label),
    .link_code(link_code), .rx_su(rx_su), .tx_su(tx_su),
    .tx_ready(tx_ready), .test_pass(test_pass), .test_retry(test_retry),
    .mgmt_alarm(mgmt_alarm), .ack_dropped(ack_dropped));
  ltmu_peer peer (.mclk(mclk), .reset_n(reset_n), .tx_su(tx_su),
    .tx_ready(tx_ready), .rx_su(rx_su), .inj(inj), .mode(mode),
    .stall(stall), .seen(seen), .seen_stb(seen_stb));
  // Pulses tallied at the falling edge, once settled
  always @(negedge mclk)
  begin
    n_pass  += int'(test_pass === 1'b1);
    n_retry += int'(test_retry === 1'b1);
    n_alarm += int'(mgmt_alarm === 1'b1);
    n_drop  += int'(ack_dropped === 1'b1);
    if (seen_stb === 1'b1 && seen.information_payload_field.signal_type_code
        === ltmu_pkg::SIG_TEST)
    begin
      n_tst++;
      t_off = cyc;
    end
    if (test_retry === 1'b1)
      dret = cyc - t_off;
  end
  // Hang guard, well above the expected run
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 9000)
    begin
      miscompares++;
      summarize();
    end
  end
  task summarize;
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task cmp_msg(input ltmu_pkg::ltmu_su_t g, input ltmu_pkg::ltmu_su_t e);
    cmp_bit(g === e, 1'b1, "message fields differ");
  endtask : cmp_msg
  task cmp_bit(input logic g, input logic e, input string m);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %0t: %s", $time, m);
    end
  endtask : cmp_bit
  function automatic ltmu_pkg::ltmu_su_t mk(ltmu_row_t r, logic [7:0] s);
    ltmu_pkg::ltmu_su_t v;
    v = '0;
    v.valid = 1'b1;
    v.service_ind = r.si;
    v.octets = ltmu_pkg::HDR_OCTETS + 5'(r.len);
    v.information_payload_field = {{15{s}}, r.len, r.spr, r.sig, r.grp,
                                   own_label};
    return v;
  endfunction : mk
  // Octets past the length and the network bits are not compared
  function automatic ltmu_pkg::ltmu_su_t norm(ltmu_pkg::ltmu_su_t v);
    v.sub_service_bits = 4'h0;
    v.information_payload_field.pattern &=
      (120'h1 << (8 * v.information_payload_field.length)) - 120'h1;
    return v;
  endfunction : norm
  function automatic ltmu_pkg::ltmu_su_t ack_of(ltmu_pkg::ltmu_su_t v);
    v.information_payload_field.signal_type_code = ltmu_pkg::SIG_ACK;
    v.information_payload_field.spare = 4'h0;
    v.information_payload_field.label[31:28] = link_code;
    return v;
  endfunction : ack_of
  task automatic watch(input int n);
    hit = 1'b0;
    repeat (n)
    begin
      @(posedge mclk);
      #1;
      if (seen_stb === 1'b1)
      begin
        hit = 1'b1;
        got = seen;
      end
    end
  endtask : watch
  task automatic send(input ltmu_pkg::ltmu_su_t v);
    @(posedge mclk);
    inj <= v;
    @(posedge mclk);
    inj.valid <= 1'b0;
  endtask : send
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    in_service <= 1'b1;
    repeat (3) @(posedge mclk);
    foreach (rows[i])
    begin
      u = mk(rows[i], 8'h30 + 8'(i));
      send(u);
      watch(60);
      cmp_bit(hit, rows[i].ans, "ack presence");
      if (rows[i].ans)
        cmp_msg(norm(got), norm(ack_of(u)));
    end
    // Back to back tests: the newest one replaces the first and alone is answered
    @(posedge mclk);
    inj <= mk(rows[0], 8'hc1);
    u = mk(rows[1], 8'hd2);
    send(u);
    watch(60);
    cmp_msg(norm(got), norm(ack_of(u)));
    // Link refuses: the owed ack must be dropped, not sent late
    stall <= 1'b1;
    n_drop = 0;
    send(mk(rows[0], 8'h77));
    watch(70);
    cmp_bit(hit || n_drop != 1, 1'b0, "ack not dropped");
    stall <= 1'b0;
    watch(20);
    cmp_bit(hit, 1'b0, "late ack sent");
    // Own test answered correctly
    n_pass = 0;
    n_retry = 0;
    originate_en <= 1'b1;
    for (k = 0; k < 900 && n_pass == 0; k++) @(posedge mclk);
    cmp_bit(n_pass == 1 && n_retry == 0, 1'b1, "own test");
    u = mk(rows[0], 8'h00);
    u.information_payload_field.label[31:28] = link_code;
    got = seen;
    got.information_payload_field.pattern = '0;
    cmp_msg(norm(got), u);
    // Wrong pattern twice, then silence twice
    for (int m = 1; m < 3; m++)
    begin
      mode <= 2'(m);
      n_pass = 0;
      n_retry = 0;
      n_alarm = 0;
      for (k = 0; k < 2000 && n_alarm == 0; k++) @(posedge mclk);
      cmp_bit(n_retry == 1 && n_alarm == 1 && n_pass == 0, 1'b1,
              "repeat and alarm");
    end
    cmp_bit(dret >= AW - 3 && dret <= AW + 4, 1'b1, "timeout span");
    // Own tests off: only acks may leave
    originate_en <= 1'b0;
    n_tst = 0;
    repeat (TP + AW + 50) @(posedge mclk);
    cmp_bit(n_tst == 0, 1'b1, "test while off");
    // Second reset in mid-run quiets every output
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    cmp_bit(tx_su.valid | test_pass | test_retry | mgmt_alarm | ack_dropped,
            1'b0, "outputs in reset");
    summarize();
  end
endmodule : ltmu_top_test
